// ===== verilog/stc_config_regs.sv
`timescale 1ns/10ps
// Overview of operation
// - Eight-bit read/write humidity trim added to every converted humidity result.
// - Trim equals the weighted sum of set bits; cleared bits add nothing.
// - Temperature floor threshold, read/write, resets to one.
// - Temperature ceiling threshold, read/write, resets to all ones.
// - Temperature code maps to code/256*165-40 degrees Celsius.
// - Humidity floor threshold, read/write, resets to zero.
// - Humidity ceiling threshold, read/write, resets to all ones.
// - Humidity code maps to code/256*100 percent relative humidity.
// - Setup bit 7 starts soft reset, self-clears when reset completes.
// - Rate field bits 6..4 zero selects one-shot, else continuous.
// - Rate codes give periods 120 s, 60 s, 10 s, 5 s, 1, 2, 5 Hz.
// - Setup bit 3 turns the heater on; resets off.
// - Setup bit 2 zero floats alert pin; one drives it.
// - Setup bit 1 sets alert polarity: zero low, one high.
// - Setup bit 0 selects clear-on-read or comparator alert behaviour.
// - Per-source enables matter only while pin drive bit is one.
// - Alarm flags clear on status read and on any reset.
// - Measurement kick starts conversion, then clears itself as it begins.
module stc_config_regs
   import stc_pkg::*;
#(
   parameter int MS_CYCLES = STC_MS_CYCLES
) (
   input  wire logic       SYS_CLK,
   input  wire logic       RESETN,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,
   input  wire logic       CONV_DONE,
   input  wire logic [7:0] RAW_TEMP,
   input  wire logic [7:0] RAW_HUMIDITY,
   output logic            CONV_START,
   output logic      [7:0] HUMIDITY_RESULT,
   output logic            HEATER_ON,
   output logic            SOFT_RESET_ACTIVE,
   output logic            ALERT_OUTPUT_PIN_O,
   output logic            ALERT_OUTPUT_PIN_OE
);
   initial begin
      if (MS_CYCLES < 1) $error("MS_CYCLES must be at least one");
   end

   // Rate code to period in milliseconds
   function automatic logic [31:0] rate_period(input logic [2:0] code);
      case (code)
         3'h1:    rate_period = 32'(STC_PER_MS_1);
         3'h2:    rate_period = 32'(STC_PER_MS_2);
         3'h3:    rate_period = 32'(STC_PER_MS_3);
         3'h4:    rate_period = 32'(STC_PER_MS_4);
         3'h5:    rate_period = 32'(STC_PER_MS_5);
         3'h6:    rate_period = 32'(STC_PER_MS_6);
         3'h7:    rate_period = 32'(STC_PER_MS_7);
         default: rate_period = 32'(STC_PER_MS_7);
      endcase
   endfunction

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] trim_reg,   trim_next;
   logic [7:0] tfloor_reg, tfloor_next;
   logic [7:0] tceil_reg,  tceil_next;
   logic [7:0] hfloor_reg, hfloor_next;
   logic [7:0] hceil_reg,  hceil_next;
   logic [7:0] setup_reg,  setup_next;
   logic [7:0] irqen_reg,  irqen_next;
   logic       kick_reg,   kick_next;
   logic [7:0] status_reg, status_next;
   logic [7:0] hum_reg,    hum_next;
   logic [7:0] rdata_reg,  rdata_next;
   logic [2:0] srst_reg,   srst_next;
   stc_state_t state_reg,  state_next;
   logic       start;
   logic       tick;
   logic       continuous;
   logic [2:0] rate;
   logic [7:0] alarm_now;
   logic [7:0] alarm_src;
   logic       alert_act;
   logic       timer_run;
   localparam logic [2:0] SRST_IDLE   = 3'h0;
   localparam logic [2:0] SRST_LAST   = 3'h1;
   localparam logic [7:0] IRQ_EN_MASK = 8'hf8;

   assign rate       = setup_reg[STC_BIT_RATE_HI:STC_BIT_RATE_LO];
   assign continuous = (rate != STC_RATE_ONESHOT);

   // Timer counts only while a continuous stream is active
   assign timer_run  = continuous && state_reg != STC_IDLE && srst_reg == SRST_IDLE;

   stc_period_timer #(
      .MS_CYCLES (MS_CYCLES)
   ) u_timer (
      .clk       (SYS_CLK),
      .rst_n     (RESETN),
      .run       (timer_run),
      .period_ms (rate_period(rate)),
      .tick      (tick)
   );

   // ----------------------------------------
   // Alarm compare
   // ----------------------------------------
   // Humidity is compared after trimming, as it is reported
   // compare result to thresholds; codes share the result scale
   always_comb begin
      alarm_now = 8'h00;
      alarm_now[STC_BIT_TH] = RAW_TEMP > tceil_reg;
      alarm_now[STC_BIT_TL] = RAW_TEMP < tfloor_reg;
      alarm_now[STC_BIT_HH] = hum_next > hceil_reg;
      alarm_now[STC_BIT_HL] = hum_next < hfloor_reg;
   end

   // ----------------------------------------
   // Register file and sequencing
   // ----------------------------------------
   always_comb begin
      trim_next   = trim_reg;
      tfloor_next = tfloor_reg;
      tceil_next  = tceil_reg;
      hfloor_next = hfloor_reg;
      hceil_next  = hceil_reg;
      setup_next  = setup_reg;
      irqen_next  = irqen_reg;
      kick_next   = kick_reg;
      status_next = status_reg;
      hum_next    = hum_reg;
      state_next  = state_reg;
      rdata_next  = rdata_reg;
      start       = 1'b0;
      // weighted sum of set bits is plain binary add
      if (CONV_DONE) begin
         hum_next = RAW_HUMIDITY + trim_reg;
      end
      if (REG_RD) begin
         case (REG_ADDR)
            STC_OFS_STATUS: rdata_next = status_reg;
            STC_OFS_IRQ_EN: rdata_next = irqen_reg;
            STC_OFS_TRIM:   rdata_next = trim_reg;
            STC_OFS_TFLOOR: rdata_next = tfloor_reg;
            STC_OFS_TCEIL:  rdata_next = tceil_reg;
            STC_OFS_HFLOOR: rdata_next = hfloor_reg;
            STC_OFS_HCEIL:  rdata_next = hceil_reg;
            STC_OFS_SETUP:  rdata_next = setup_reg;
            STC_OFS_MEAS:   rdata_next = {7'h00, kick_reg};
            default:        rdata_next = 8'h00;
         endcase
         if (REG_ADDR == STC_OFS_STATUS) begin
            status_next = 8'h00;
         end
      end
      // Hardware set wins over the read clear
      if (CONV_DONE) begin
         status_next = status_next | alarm_now;
      end
      if (REG_WR) begin
         case (REG_ADDR)
            // Enable bits 2..0 always read zero; unused bit 7 keeps what is written
            STC_OFS_IRQ_EN: irqen_next  = REG_WDATA & IRQ_EN_MASK;
            STC_OFS_TRIM:   trim_next   = REG_WDATA;
            STC_OFS_TFLOOR: tfloor_next = REG_WDATA;
            STC_OFS_TCEIL:  tceil_next  = REG_WDATA;
            STC_OFS_HFLOOR: hfloor_next = REG_WDATA;
            STC_OFS_HCEIL:  hceil_next  = REG_WDATA;
            STC_OFS_SETUP:  setup_next  = REG_WDATA;
            STC_OFS_MEAS:   kick_next   = REG_WDATA[STC_BIT_KICK];
            default:        ;
         endcase
      end
      // Conversion sequencer
      case (state_reg)
         STC_IDLE: begin
            if (kick_reg) begin
               start      = 1'b1;
               kick_next  = 1'b0;
               state_next = STC_CONV;
            end
         end
         STC_CONV: begin
            if (CONV_DONE) begin
               state_next = continuous ? STC_WAIT : STC_IDLE;
            end
         end
         STC_WAIT: begin
            if (!continuous) begin
               state_next = STC_IDLE;
            end else if (tick) begin
               start      = 1'b1;
               state_next = STC_CONV;
            end
         end
         default: state_next = STC_IDLE;
      endcase
      // soft reset restores defaults, and bit self-clears in the same cycle
      // No conversion may start on settings about to be discarded
      if (srst_reg != SRST_IDLE) begin
         start     = 1'b0;
         if (srst_reg == SRST_LAST) begin
            trim_next   = STC_RST_TRIM;
            tfloor_next = STC_RST_TFLOOR;
            tceil_next  = STC_RST_TCEIL;
            hfloor_next = STC_RST_HFLOOR;
            hceil_next  = STC_RST_HCEIL;
            setup_next  = STC_RST_SETUP;
            irqen_next  = 8'h00;
            kick_next   = 1'b0;
            status_next = 8'h00;
            hum_next    = 8'h00;
            state_next  = STC_IDLE;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         trim_reg   <= STC_RST_TRIM;
         tfloor_reg <= STC_RST_TFLOOR;
         tceil_reg  <= STC_RST_TCEIL;
         hfloor_reg <= STC_RST_HFLOOR;
         hceil_reg  <= STC_RST_HCEIL;
         setup_reg  <= STC_RST_SETUP;
         irqen_reg  <= 8'h00;
         kick_reg   <= 1'b0;
         status_reg <= 8'h00;
         hum_reg    <= 8'h00;
         state_reg  <= STC_IDLE;
         rdata_reg  <= 8'h00;
      end else begin
         trim_reg   <= trim_next;
         tfloor_reg <= tfloor_next;
         tceil_reg  <= tceil_next;
         hfloor_reg <= hfloor_next;
         hceil_reg  <= hceil_next;
         setup_reg  <= setup_next;
         irqen_reg  <= irqen_next;
         kick_reg   <= kick_next;
         status_reg <= status_next;
         hum_reg    <= hum_next;
         state_reg  <= state_next;
         rdata_reg  <= rdata_next;
      end
   end

   // ----------------------------------------
   // Soft reset countdown
   // ----------------------------------------
   // bit 7 arms the countdown
   always_comb begin
      srst_next = srst_reg;
      if (srst_reg != SRST_IDLE) begin
         srst_next = srst_reg - 3'h1;
      end else if (setup_reg[STC_BIT_SOFTRST]) begin
         srst_next = 3'(STC_RST_HOLD);
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         srst_reg <= SRST_IDLE;
      end else begin
         srst_reg <= srst_next;
      end
   end

   // ----------------------------------------
   // Alert pin
   // ----------------------------------------
   // mode bit selects
   // latched flags alone or latched flags plus live condition
   // Comparator mode also shows a live alarm in the done cycle
   assign alarm_src = setup_reg[STC_BIT_MODE] ? (alarm_now & {8{CONV_DONE}}) | status_reg
                                              : status_reg;
   assign alert_act = setup_reg[STC_BIT_DRIVE] && ((alarm_src & irqen_reg) != 8'h00);

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign CONV_START        = start;
   assign REG_RDATA         = rdata_reg;
   assign HUMIDITY_RESULT   = hum_reg;
   assign HEATER_ON         = setup_reg[STC_BIT_HEAT];
   assign SOFT_RESET_ACTIVE = setup_reg[STC_BIT_SOFTRST];
   assign ALERT_OUTPUT_PIN_O  = setup_reg[STC_BIT_POL] ? alert_act : ~alert_act;
   assign ALERT_OUTPUT_PIN_OE = setup_reg[STC_BIT_DRIVE];
endmodule

// ===== verilog/stc_pkg.sv
package stc_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] STC_OFS_STATUS  = 8'h04;
   localparam logic [7:0] STC_OFS_IRQ_EN  = 8'h07;
   localparam logic [7:0] STC_OFS_TRIM    = 8'h09;
   localparam logic [7:0] STC_OFS_TFLOOR  = 8'h0a;
   localparam logic [7:0] STC_OFS_TCEIL   = 8'h0b;
   localparam logic [7:0] STC_OFS_HFLOOR  = 8'h0c;
   localparam logic [7:0] STC_OFS_HCEIL   = 8'h0d;
   localparam logic [7:0] STC_OFS_SETUP   = 8'h0e;
   localparam logic [7:0] STC_OFS_MEAS    = 8'h0f;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] STC_RST_TRIM    = 8'h00;
   localparam logic [7:0] STC_RST_TFLOOR  = 8'h01;
   localparam logic [7:0] STC_RST_TCEIL   = 8'hff;
   localparam logic [7:0] STC_RST_HFLOOR  = 8'h00;
   localparam logic [7:0] STC_RST_HCEIL   = 8'hff;
   localparam logic [7:0] STC_RST_SETUP   = 8'h00;
   // ----------------------------------------
   // Setup field positions
   // ----------------------------------------
   localparam int STC_BIT_SOFTRST = 7;
   localparam int STC_BIT_RATE_HI = 6;
   localparam int STC_BIT_RATE_LO = 4;
   localparam int STC_BIT_HEAT    = 3;
   localparam int STC_BIT_DRIVE   = 2;
   localparam int STC_BIT_POL     = 1;
   localparam int STC_BIT_MODE    = 0;
   localparam int STC_BIT_KICK    = 0;
   // Status and enable bits: ceiling/floor temp, ceiling/floor humidity
   localparam int STC_BIT_TH      = 6;
   localparam int STC_BIT_TL      = 5;
   localparam int STC_BIT_HH      = 4;
   localparam int STC_BIT_HL      = 3;
   // ----------------------------------------
   // Sample periods in milliseconds, per rate code
   // ----------------------------------------
   localparam int STC_CLK_HZ      = 20000000;
   localparam int STC_MS_CYCLES   = STC_CLK_HZ / 1000;
   localparam int STC_PER_MS_1    = 120000;
   localparam int STC_PER_MS_2    = 60000;
   localparam int STC_PER_MS_3    = 10000;
   localparam int STC_PER_MS_4    = 5000;
   localparam int STC_PER_MS_5    = 1000;
   localparam int STC_PER_MS_6    = 500;
   localparam int STC_PER_MS_7    = 200;
   localparam logic [2:0] STC_RATE_ONESHOT = 3'h0;
   localparam int STC_RST_HOLD    = 4;

   typedef enum logic [1:0] {
      STC_IDLE  = 2'b00,
      STC_CONV  = 2'b01,
      STC_WAIT  = 2'b10
   } stc_state_t;
endpackage

// ===== verilog/stc_period_timer.sv
`timescale 1ns/10ps
module stc_period_timer
   import stc_pkg::*;
#(
   parameter int MS_CYCLES = STC_MS_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        run,
   input  wire logic [31:0] period_ms,
   output logic             tick
);
   initial begin
      if (MS_CYCLES < 1) $error("MS_CYCLES must be at least one");
   end

   logic [31:0] cyc_reg;
   logic [31:0] cyc_next;
   logic [31:0] ms_reg;
   logic [31:0] ms_next;

   // ----------------------------------------
   // Millisecond prescaler and period count
   // ----------------------------------------
   always_comb begin
      cyc_next = cyc_reg;
      ms_next  = ms_reg;
      tick     = 1'b0;
      if (!run) begin
         cyc_next = '0;
         ms_next  = '0;
      end else if (cyc_reg == 32'(MS_CYCLES - 1)) begin
         cyc_next = '0;
         if (ms_reg + 32'h1 >= period_ms) begin
            ms_next = '0;
            tick    = 1'b1;
         end else begin
            ms_next = ms_reg + 32'h1;
         end
      end else begin
         cyc_next = cyc_reg + 32'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cyc_reg <= '0;
         ms_reg  <= '0;
      end else begin
         cyc_reg <= cyc_next;
         ms_reg  <= ms_next;
      end
   end
endmodule

// ===== tb/stc_conv_model.sv
`timescale 1ns/10ps
module stc_conv_model #(
   parameter int DELAY = 3
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       start,
   input  wire logic [7:0] temp_code,
   input  wire logic [7:0] hum_code,
   output logic            done,
   output logic      [7:0] raw_temp,
   output logic      [7:0] raw_hum
);
   logic [7:0] cnt_reg;
   assign raw_temp = done ? temp_code : ~temp_code;
   assign raw_hum  = done ? hum_code : ~hum_code;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 8'h00;
         done    <= 1'b0;
      end else begin
         done <= (cnt_reg == 8'h01);
         if (start) begin
            cnt_reg <= 8'(DELAY);
         end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end
endmodule

// ===== tb/stc_config_regs_chk.sv
`timescale 1ns/10ps
module stc_config_regs_chk
   import stc_pkg::*;
#(
   parameter int MS_CYCLES = STC_MS_CYCLES
) (
   input wire logic       SYS_CLK,
   input wire logic       RESETN,
   input wire logic       REG_WR,
   input wire logic       REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic       CONV_DONE,
   input wire logic [7:0] RAW_HUMIDITY,
   input wire logic       CONV_START,
   input wire logic [7:0] HUMIDITY_RESULT,
   input wire logic       HEATER_ON,
   input wire logic       SOFT_RESET_ACTIVE,
   input wire logic       ALERT_OUTPUT_PIN_O,
   input wire logic       ALERT_OUTPUT_PIN_OE
);
   logic [7:0] trim_reg;
   logic [7:0] setup_reg;
   // ----------------------------------------
   // Shadow copies of trim and setup
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         trim_reg  <= 8'h00;
         setup_reg <= 8'h00;
      end else if (SOFT_RESET_ACTIVE) begin
         trim_reg  <= 8'h00;
         setup_reg <= 8'h00;
      end else if (REG_WR && REG_ADDR == STC_OFS_TRIM) begin
         trim_reg <= REG_WDATA;
      end else if (REG_WR && REG_ADDR == STC_OFS_SETUP) begin
         setup_reg <= REG_WDATA;
      end
   end
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   sequence setup_wr;
      REG_WR && REG_ADDR == STC_OFS_SETUP;
   endsequence
   sequence status_rd;
      REG_RD && REG_ADDR == STC_OFS_STATUS && !CONV_DONE ##1 !CONV_DONE;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   drive_follow_a : assert property (
      setup_wr |=> ALERT_OUTPUT_PIN_OE == $past(REG_WDATA[STC_BIT_DRIVE]))
      else $error("alert drive bit not applied");
   heat_follow_a : assert property (
      setup_wr |=> HEATER_ON == $past(REG_WDATA[STC_BIT_HEAT]))
      else $error("heater bit not applied");
   soft_reset_a : assert property (
      setup_wr ##0 REG_WDATA[STC_BIT_SOFTRST] |=> SOFT_RESET_ACTIVE ##[1:6]
      (!SOFT_RESET_ACTIVE && !HEATER_ON && !ALERT_OUTPUT_PIN_OE))
      else $error("soft reset did not complete");
   start_pulse_a : assert property (
      CONV_START |=> !CONV_START)
      else $error("start pulse longer than one cycle");
   kick_start_a : assert property (
      REG_WR && REG_ADDR == STC_OFS_MEAS && REG_WDATA[STC_BIT_KICK]
      && setup_reg[6:4] == STC_RATE_ONESHOT |-> ##[1:20] CONV_START)
      else $error("kick did not start a conversion");
   trim_sum_a : assert property (
      CONV_DONE |=> HUMIDITY_RESULT == 8'($past(RAW_HUMIDITY) + $past(trim_reg)))
      else $error("trimmed humidity wrong");
   alert_clear_a : assert property (
      status_rd |=> ALERT_OUTPUT_PIN_O == !setup_reg[STC_BIT_POL])
      else $error("alert still asserted after status read");
   one_shot_a : assert property (
      CONV_DONE && setup_reg[6:4] == STC_RATE_ONESHOT |=> (!CONV_START) [*6])
      else $error("one-shot mode restarted conversion");
endmodule
bind stc_config_regs stc_config_regs_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
   .SYS_CLK, .RESETN, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .CONV_DONE,
   .RAW_HUMIDITY, .CONV_START, .HUMIDITY_RESULT, .HEATER_ON, .SOFT_RESET_ACTIVE,
   .ALERT_OUTPUT_PIN_O, .ALERT_OUTPUT_PIN_OE);

// ===== tb/tb.sv
`timescale 1ns/10ps
`define CHK(a, e, m) begin \
   total_checks++; \
   if ((a) !== (e)) begin \
      n_fail++; \
      $display("mismatch %0t %s", $time, m); \
   end \
end
module tb
   import stc_pkg::*;
;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic       wr_s = 1'b0;
   logic       rd_s = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] tv = 8'h00;
   logic [7:0] hv = 8'h00;
   logic [7:0] rdata, rt, rh, hres;
   logic       done, start, heat, sra, ao, aoe;
   int         n_fail = 0;
   int         total_checks = 0;
   always #25 clk = ~clk;
   stc_config_regs #(.MS_CYCLES(2)) DUT (
      .SYS_CLK(clk), .RESETN(rstn), .REG_WR(wr_s), .REG_RD(rd_s), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_RDATA(rdata), .CONV_DONE(done), .RAW_TEMP(rt),
      .RAW_HUMIDITY(rh), .CONV_START(start), .HUMIDITY_RESULT(hres), .HEATER_ON(heat),
      .SOFT_RESET_ACTIVE(sra), .ALERT_OUTPUT_PIN_O(ao), .ALERT_OUTPUT_PIN_OE(aoe));
   stc_conv_model #(.DELAY(3)) u_conv (
      .clk(clk), .rst_n(rstn), .start(start), .temp_code(tv), .hum_code(hv),
      .done(done), .raw_temp(rt), .raw_hum(rh));
   task automatic give_verdict();
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic expire();
      n_fail++;
      give_verdict();
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      `CHK(rdata, e, "read data")
   endtask
   task automatic conv(input logic [7:0] t, input logic [7:0] h);
      int i;
      tv <= t;
      hv <= h;
      wr(STC_OFS_MEAS, 8'h01);
      for (i = 0; i < 50 && done !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 50) expire();
      @(posedge clk);
      #1;
   endtask
   task automatic sreset();
      int i;
      wr(STC_OFS_SETUP, 8'h88);
      #1;
      `CHK(sra, 1'b1, "soft reset flag")
      for (i = 0; i < 20 && sra !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 20) expire();
   endtask
   initial begin
      logic [7:0]  rv [6];
      logic [31:0] cs [6];
      int          pm [5];
      int          n;
      rv = '{STC_RST_TRIM, 8'h01, 8'hff, 8'h00, 8'hff, 8'h00};
      cs = '{32'h90604006, 32'h10602004, 32'h60901007, 32'h60100805,
             32'h80400006, 32'h90604002};
      // Start-to-start period in cycles for rate codes 3 to 7 at two cycles per ms
      pm = '{10000 * 2, 5000 * 2, 1000 * 2, 500 * 2, 200 * 2};
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(8'(9 + i), rv[i]);
      rd(8'h20, 8'h00);
      `CHK(heat, 1'b0, "heater at reset")
      for (int i = 0; i < 6; i++) begin
         wr(8'(9 + i), 8'h1c + 8'(i) * 8'h11);
         rd(8'(9 + i), 8'h1c + 8'(i) * 8'h11);
      end
      wr(STC_OFS_SETUP, 8'h08);
      #1;
      `CHK({heat, aoe}, 2'b10, "heater on")
      wr(STC_OFS_SETUP, 8'h04);
      #1;
      `CHK({heat, aoe}, 2'b01, "pin driven")
      for (int i = 0; i < 4; i++) wr(8'(10 + i), i[0] ? 8'h80 : 8'h40);
      wr(STC_OFS_IRQ_EN, 8'h78);
      wr(STC_OFS_TRIM, 8'h05);
      conv(8'h50, 8'h50);
      `CHK(hres, 8'h55, "trim add")
      wr(STC_OFS_TRIM, 8'hff);
      conv(8'h50, 8'h50);
      `CHK(hres, 8'h4f, "negative trim")
      rd(STC_OFS_MEAS, 8'h00);
      wr(STC_OFS_TRIM, 8'h00);
      for (int i = 0; i < 6; i++) begin
         wr(STC_OFS_SETUP, cs[i][7:0]);
         conv(cs[i][31:24], cs[i][23:16]);
         @(posedge clk);
         #1;
         `CHK(aoe, cs[i][2], "pin drive")
         if (cs[i][2]) `CHK(ao, cs[i][1] ~^ (cs[i][15:8] != 0), "alert level")
         rd(STC_OFS_STATUS, cs[i][15:8]);
         @(posedge clk);
         #1;
         `CHK(ao, ~cs[i][1], "alert after read")
      end
      wr(STC_OFS_TCEIL, 8'h33);
      sreset();
      rd(STC_OFS_TCEIL, 8'hff);
      rd(STC_OFS_SETUP, 8'h00);
      for (int r = 3; r < 8; r++) begin
         sreset();
         wr(STC_OFS_SETUP, {1'b0, 3'(r), 4'h0});
         conv(8'h50, 8'h50);
         for (n = 0; n < 25000 && start !== 1'b1; n++) begin
            @(posedge clk);
            #1;
         end
         // The count starts five cycles after the first start: model delay plus two
         `CHK(n >= pm[r - 3] - 6 && n <= pm[r - 3] - 4, 1'b1, "sample period")
      end
      sreset();
      conv(8'h50, 8'h50);
      for (n = 0; n < 1000 && start !== 1'b1; n++) begin
         @(posedge clk);
         #1;
      end
      `CHK(n, 1000, "one-shot restarted")
      give_verdict();
   end
endmodule
